// ### amt_tracker.v
/*
  absolute multiturn tracker: usage select, wrapping revolution count, encoder
  setup and limit rewrite gating, encoder alarm latching with 3-bit alarm code.
  assumes RESET_I is the power-on reset; encoder event inputs are pins and are
  resynchronised here; config inputs are static drive parameters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "amt_defines.vh"
module amt_tracker #(
  parameter LIMIT_W = `AMT_LIMIT_W
) (
  input wire CORE_CLK_I,
  input wire RESET_I,
  input wire ENCODER_USAGE_SELECT_I,
  input wire [LIMIT_W-1:0] MULTITURN_WRAP_LIMIT_I,
  input wire [LIMIT_W-1:0] ENC_STORED_LIMIT_I,
  input wire ZERO_CROSS_POS_I,
  input wire ZERO_CROSS_NEG_I,
  input wire BACKUP_FAULT_I,
  input wire CHECKSUM_FAULT_I,
  input wire MONITOR_FAULT_I,
  input wire SERVO_ON_I,
  input wire ALARM_RESET_I,
  input wire ENCODER_SETUP_FUNCTION_I,
  input wire ENCODER_LIMIT_REWRITE_FUNCTION_I,
  output reg INCREMENTAL_MODE_O,
  output reg [LIMIT_W-1:0] ACTIVE_LIMIT_O,
  output reg [LIMIT_W-1:0] MULTITURN_COUNT_O,
  output reg SIGNED_MODE_O,
  output reg SETUP_ACCEPT_O,
  output reg SETUP_REFUSE_O,
  output reg LIMIT_WRITE_O,
  output reg [LIMIT_W-1:0] LIMIT_WRITE_DATA_O,
  output reg LIMIT_DISAGREEMENT_ALARM_O,
  output reg BACKUP_ALARM_O,
  output reg CHECKSUM_ALARM_O,
  output reg MONITOR_ALARM_O,
  output reg ALARM_CODE_BIT_ONE_O,
  output reg ALARM_CODE_BIT_TWO_O,
  output reg ALARM_CODE_BIT_THREE_O
);
  localparam [LIMIT_W-1:0] FULL = {LIMIT_W{1'b1}};
  localparam [LIMIT_W-1:0] ONE = {{(LIMIT_W-1){1'b0}}, 1'b1};
  localparam [LIMIT_W-1:0] ZERO = {LIMIT_W{1'b0}};

  // pin inputs: three stages each, a change counts once stages two and three agree;
  // the agree stage costs one edge of latency but rejects a lone glitch on the cable
  localparam NPIN = 5;
  localparam PIN_POS = 0;
  localparam PIN_NEG = 1;
  localparam PIN_BACKUP = 2;
  localparam PIN_CHECKSUM = 3;
  localparam PIN_MONITOR = 4;
  wire [NPIN-1:0] pins = {MONITOR_FAULT_I, CHECKSUM_FAULT_I, BACKUP_FAULT_I,
    ZERO_CROSS_NEG_I, ZERO_CROSS_POS_I};
  wire [NPIN-1:0] flt;
  reg flt_prev_pos_q, flt_prev_neg_q;
  reg cfg_done_q;
  // edge detectors reset to the idle low level, so no false step follows reset
  wire pos_step = flt[PIN_POS] & ~flt_prev_pos_q;
  wire neg_step = flt[PIN_NEG] & ~flt_prev_neg_q;
  wire setup_ok = ENCODER_SETUP_FUNCTION_I & ~SERVO_ON_I;
  wire rewrite_ok = ENCODER_LIMIT_REWRITE_FUNCTION_I & LIMIT_DISAGREEMENT_ALARM_O;
  wire count_run;
  wire [LIMIT_W-1:0] count_d;
  wire [2:0] code;

  // next count for one step of the motor
  function [LIMIT_W-1:0] step_count;
    input [LIMIT_W-1:0] cur;
    input [LIMIT_W-1:0] lim;
    input signed_mode;
    input up;
    begin
      if (signed_mode) begin
        // two's complement wraps -32768/32767 naturally
        step_count = up ? cur + ONE : cur - ONE;
      end else if (up) begin
        // a count above the limit also returns to zero rather than running on
        step_count = (cur >= lim) ? ZERO : cur + ONE;
      end else begin
        step_count = (cur == ZERO) ? lim : cur - ONE;
      end
    end
  endfunction

  // pin code of the highest-priority active alarm; values are pin levels, on is low
  function [2:0] alarm_code;
    input disagree;
    input monitor;
    input backup;
    input checksum;
    begin
      if (disagree) begin
        alarm_code = `AMT_CODE_DISAGREE;
      end else if (monitor) begin
        alarm_code = `AMT_CODE_MONITOR;
      end else if (backup) begin
        alarm_code = `AMT_CODE_BACKUP;
      end else if (checksum) begin
        alarm_code = `AMT_CODE_CHECKSUM;
      end else begin
        alarm_code = `AMT_CODE_NONE;
      end
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg flt_q;
      always @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          flt_q <= 1'b0;
        end else begin
          s1_q <= pins[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // hold the old level while stages two and three disagree
          flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
        end
      end
      assign flt[gi] = flt_q;
    end
  endgenerate

  // configuration captured once after reset release, so later changes wait for power cycle
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_done_q <= 1'b0;
      INCREMENTAL_MODE_O <= `AMT_USAGE_ABSOLUTE;
      ACTIVE_LIMIT_O <= `AMT_LIMIT_DEFAULT;
      SIGNED_MODE_O <= 1'b1;
      LIMIT_DISAGREEMENT_ALARM_O <= 1'b0;
    end else begin
      cfg_done_q <= 1'b1;
      if (!cfg_done_q) begin
        INCREMENTAL_MODE_O <= ENCODER_USAGE_SELECT_I;
        ACTIVE_LIMIT_O <= MULTITURN_WRAP_LIMIT_I;
        SIGNED_MODE_O <= (MULTITURN_WRAP_LIMIT_I == FULL);
        // incremental use has no multiturn data, so no comparison then
        LIMIT_DISAGREEMENT_ALARM_O <= (ENCODER_USAGE_SELECT_I == `AMT_USAGE_ABSOLUTE) &&
          (MULTITURN_WRAP_LIMIT_I != ENC_STORED_LIMIT_I);
      end else if (rewrite_ok) begin
        LIMIT_DISAGREEMENT_ALARM_O <= 1'b0;
      end
    end
  end

  // count frozen while the limit is unsettled or the alarm stands;
  // steps in both directions in one cycle cancel and are dropped
  assign count_run = cfg_done_q &&
    !INCREMENTAL_MODE_O &&
    !LIMIT_DISAGREEMENT_ALARM_O &&
    (pos_step ^ neg_step);
  assign count_d = step_count(MULTITURN_COUNT_O, ACTIVE_LIMIT_O, SIGNED_MODE_O, pos_step);

  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flt_prev_pos_q <= 1'b0;
      flt_prev_neg_q <= 1'b0;
      MULTITURN_COUNT_O <= ZERO;
    end else begin
      flt_prev_pos_q <= flt[PIN_POS];
      flt_prev_neg_q <= flt[PIN_NEG];
      if (count_run) begin
        MULTITURN_COUNT_O <= count_d;
      end
    end
  end

  // alarms: fault set wins over any clear in the same cycle
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      BACKUP_ALARM_O <= 1'b0;
      CHECKSUM_ALARM_O <= 1'b0;
      MONITOR_ALARM_O <= 1'b0;
      SETUP_ACCEPT_O <= 1'b0;
      SETUP_REFUSE_O <= 1'b0;
      LIMIT_WRITE_O <= 1'b0;
      LIMIT_WRITE_DATA_O <= ZERO;
    end else begin
      SETUP_ACCEPT_O <= setup_ok;
      SETUP_REFUSE_O <= ENCODER_SETUP_FUNCTION_I & SERVO_ON_I;
      // alarm reset deliberately unused here
      BACKUP_ALARM_O <= flt[PIN_BACKUP] | (BACKUP_ALARM_O & ~setup_ok);
      CHECKSUM_ALARM_O <= flt[PIN_CHECKSUM] | (CHECKSUM_ALARM_O & ~setup_ok);
      // only a power-on reset releases the monitor alarm
      MONITOR_ALARM_O <= flt[PIN_MONITOR] | MONITOR_ALARM_O;
      LIMIT_WRITE_O <= rewrite_ok;
      // the copied limit is not checked: a wrong drive limit lands in the encoder as is
      if (rewrite_ok) begin
        LIMIT_WRITE_DATA_O <= ACTIVE_LIMIT_O;
      end
    end
  end

  // code pins trail the alarm flags by one edge, since they come from flip-flops
  assign code = alarm_code(LIMIT_DISAGREEMENT_ALARM_O, MONITOR_ALARM_O, BACKUP_ALARM_O,
    CHECKSUM_ALARM_O);

  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ALARM_CODE_BIT_ONE_O <= 1'b1;
      ALARM_CODE_BIT_TWO_O <= 1'b1;
      ALARM_CODE_BIT_THREE_O <= 1'b1;
    end else begin
      ALARM_CODE_BIT_ONE_O <= code[0];
      ALARM_CODE_BIT_TWO_O <= code[1];
      ALARM_CODE_BIT_THREE_O <= code[2];
    end
  end

  // alarm reset clears none of the encoder alarms kept here, so it is only parked
  wire unused_ok = ALARM_RESET_I;
endmodule // amt_tracker
`default_nettype wire

// ### amt_defines.vh
/*
  constants for the absolute multiturn tracker: limits, alarm codes, usage encodings.
  assumes inclusion by amt_tracker.v only; definitions only.
*/
`ifndef AMT_DEFINES_VH
`define AMT_DEFINES_VH
`define AMT_LIMIT_W 16
`define AMT_LIMIT_DEFAULT 16'hffff
`define AMT_USAGE_ABSOLUTE 1'b0
`define AMT_USAGE_INCREMENTAL 1'b1
`define AMT_CODE_NONE 3'h7
`define AMT_CODE_DISAGREE 3'h2
`define AMT_CODE_BACKUP 3'h0
`define AMT_CODE_CHECKSUM 3'h4
`define AMT_CODE_MONITOR 3'h1
`endif

// ### amt_tracker_asserts.sv
/* port checker for amt_tracker, bound from the bench top file.
   assumes 16-bit limit and count ports and RESET_I as power-on reset. */
`timescale 1ns/1ps
`default_nettype none
module amt_tracker_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic SERVO_ON_I,
  input wire logic ENCODER_SETUP_FUNCTION_I,
  input wire logic SETUP_ACCEPT_O,
  input wire logic SETUP_REFUSE_O,
  input wire logic BACKUP_ALARM_O,
  input wire logic MONITOR_ALARM_O,
  input wire logic LIMIT_DISAGREEMENT_ALARM_O,
  input wire logic LIMIT_WRITE_O,
  input wire logic [15:0] LIMIT_WRITE_DATA_O,
  input wire logic [15:0] ACTIVE_LIMIT_O,
  input wire logic [15:0] MULTITURN_COUNT_O,
  input wire logic SIGNED_MODE_O,
  input wire logic ALARM_CODE_BIT_ONE_O,
  input wire logic ALARM_CODE_BIT_TWO_O,
  input wire logic ALARM_CODE_BIT_THREE_O
);
  logic [1:0] st_q;
  // config latches at edge one, so stability is only judged from edge three
  always @(posedge CORE_CLK_I or posedge RESET_I) begin
    if (RESET_I) st_q <= 2'b00;
    else st_q <= {st_q[0], 1'b1};
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  chk_setup_answer: assert property (ENCODER_SETUP_FUNCTION_I |=>
    SETUP_ACCEPT_O == !$past(SERVO_ON_I) && SETUP_REFUSE_O == $past(SERVO_ON_I))
    else $error("setup answer wrong");
  chk_backup_hold: assert property (BACKUP_ALARM_O && !ENCODER_SETUP_FUNCTION_I |=> BACKUP_ALARM_O)
    else $error("backup alarm dropped");
  chk_monitor_latch: assert property (MONITOR_ALARM_O |=> MONITOR_ALARM_O)
    else $error("monitor alarm dropped");
  chk_code_disagree: assert property ($past(LIMIT_DISAGREEMENT_ALARM_O) && LIMIT_DISAGREEMENT_ALARM_O |->
    {ALARM_CODE_BIT_ONE_O, ALARM_CODE_BIT_TWO_O, ALARM_CODE_BIT_THREE_O} == 3'b010)
    else $error("disagreement code wrong");
  chk_rewrite_gate: assert property (LIMIT_WRITE_O |-> $past(LIMIT_DISAGREEMENT_ALARM_O) &&
    !LIMIT_DISAGREEMENT_ALARM_O && LIMIT_WRITE_DATA_O == ACTIVE_LIMIT_O) else $error("bad rewrite");
  chk_limit_hold: assert property (st_q[1] |-> $stable(ACTIVE_LIMIT_O))
    else $error("limit changed without reset");
  chk_signed_mode: assert property (SIGNED_MODE_O == (ACTIVE_LIMIT_O == 16'hffff))
    else $error("signed mode wrong");
  chk_count_range: assert property (!SIGNED_MODE_O |-> MULTITURN_COUNT_O <= ACTIVE_LIMIT_O)
    else $error("count above limit");
  chk_count_step: assert property ($changed(MULTITURN_COUNT_O) |->
    MULTITURN_COUNT_O == $past(MULTITURN_COUNT_O) + 16'h1 ||
    MULTITURN_COUNT_O == $past(MULTITURN_COUNT_O) - 16'h1 || !SIGNED_MODE_O &&
    (MULTITURN_COUNT_O == 16'h0 || MULTITURN_COUNT_O == ACTIVE_LIMIT_O)) else $error("bad step");
endmodule // amt_tracker_asserts
`default_nettype wire

// ### amt_enc_model.sv
/* encoder model: zero-crossing pins and a non-volatile stored limit.
   assumes the bench calls turn() from its stimulus process. */
`timescale 1ns/1ps
`default_nettype none
module amt_enc_model (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [15:0] wd_i,
  output var logic pos_o,
  output var logic neg_o,
  output var logic [15:0] lim_o
);
  // stored limit survives power cycles, like the real encoder memory
  initial lim_o = 16'hffff;
  initial pos_o = 1'b0;
  initial neg_o = 1'b0;
  always @(posedge clk_i) begin
    if (wr_i) lim_o <= wd_i;
  end
  task turn(input logic d);
    @(negedge clk_i);
    pos_o = d;
    neg_o = !d;
    repeat (4) @(negedge clk_i);
    pos_o = 1'b0;
    neg_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // amt_enc_model
`default_nettype wire

// ### absolute_multiturn_tracker_tb.sv
/* self-checking bench for amt_tracker with the encoder model.
   assumes amt_tracker_asserts.sv and amt_enc_model.sv compile first. */
`timescale 1ns/1ps
`default_nettype none
module absolute_multiturn_tracker_tb;
  logic CORE_CLK_I, RESET_I, ENCODER_USAGE_SELECT_I, SERVO_ON_I, ALARM_RESET_I, BACKUP_FAULT_I;
  logic CHECKSUM_FAULT_I, MONITOR_FAULT_I, ENCODER_SETUP_FUNCTION_I, ENCODER_LIMIT_REWRITE_FUNCTION_I;
  logic [15:0] MULTITURN_WRAP_LIMIT_I;
  wire logic [15:0] ENC_STORED_LIMIT_I, ACTIVE_LIMIT_O, MULTITURN_COUNT_O, LIMIT_WRITE_DATA_O;
  wire logic ZERO_CROSS_POS_I, ZERO_CROSS_NEG_I, INCREMENTAL_MODE_O, SIGNED_MODE_O, LIMIT_WRITE_O;
  wire logic SETUP_ACCEPT_O, SETUP_REFUSE_O, LIMIT_DISAGREEMENT_ALARM_O, BACKUP_ALARM_O;
  wire logic CHECKSUM_ALARM_O, MONITOR_ALARM_O, ALARM_CODE_BIT_ONE_O, ALARM_CODE_BIT_TWO_O;
  wire logic ALARM_CODE_BIT_THREE_O;
  int n_fail, check_count, lim;
  amt_tracker amt_tracker_i (.*);
  amt_enc_model amt_enc_model_i (.clk_i(CORE_CLK_I), .wr_i(LIMIT_WRITE_O),
    .wd_i(LIMIT_WRITE_DATA_O), .pos_o(ZERO_CROSS_POS_I), .neg_o(ZERO_CROSS_NEG_I),
    .lim_o(ENC_STORED_LIMIT_I));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task power(input logic u, input logic [15:0] l);
    RESET_I = 1'b1;
    ENCODER_USAGE_SELECT_I = u;
    MULTITURN_WRAP_LIMIT_I = l;
    repeat (20) @(negedge CORE_CLK_I);
    RESET_I = 1'b0;
    repeat (3) @(negedge CORE_CLK_I);
  endtask
  task automatic pulse(ref logic s, input logic srv);
    SERVO_ON_I = srv;
    s = 1'b1;
    @(negedge CORE_CLK_I);
    s = 1'b0;
    @(negedge CORE_CLK_I);
  endtask
  initial begin
    CORE_CLK_I = 1'b0;
    forever #4 CORE_CLK_I = ~CORE_CLK_I;
  end
  initial begin
    repeat (5000) @(posedge CORE_CLK_I);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {SERVO_ON_I, ALARM_RESET_I, BACKUP_FAULT_I, CHECKSUM_FAULT_I, MONITOR_FAULT_I} = 5'h0;
    {ENCODER_SETUP_FUNCTION_I, ENCODER_LIMIT_REWRITE_FUNCTION_I} = 2'h0;
    n_fail = 0;
    check_count = 0;
    lim = $urandom(32'hc41916da);
    lim = 2 + $urandom % 6;
    power(1'b0, lim[15:0]);
    chk(INCREMENTAL_MODE_O, 1'b0);
    chk(LIMIT_DISAGREEMENT_ALARM_O, 1'b1);
    chk({ALARM_CODE_BIT_ONE_O, ALARM_CODE_BIT_TWO_O, ALARM_CODE_BIT_THREE_O}, 3'b010);
    MULTITURN_WRAP_LIMIT_I = 16'h0;
    amt_enc_model_i.turn(1'b1);
    chk(MULTITURN_COUNT_O, 16'h0);
    chk(ACTIVE_LIMIT_O, lim[15:0]);
    pulse(ENCODER_LIMIT_REWRITE_FUNCTION_I, 1'b1);
    chk(ENC_STORED_LIMIT_I, lim[15:0]);
    chk({ALARM_CODE_BIT_ONE_O, ALARM_CODE_BIT_TWO_O, ALARM_CODE_BIT_THREE_O}, 3'b111);
    amt_enc_model_i.turn(1'b0);
    chk(MULTITURN_COUNT_O, lim[15:0]);
    amt_enc_model_i.turn(1'b1);
    chk(MULTITURN_COUNT_O, 16'h0);
    for (int i = 1; i <= lim; i++) begin
      amt_enc_model_i.turn(1'b1);
      chk(MULTITURN_COUNT_O, i[15:0]);
    end
    {BACKUP_FAULT_I, CHECKSUM_FAULT_I, MONITOR_FAULT_I} = 3'h7;
    repeat (8) @(negedge CORE_CLK_I);
    {BACKUP_FAULT_I, CHECKSUM_FAULT_I, MONITOR_FAULT_I} = 3'h0;
    pulse(ALARM_RESET_I, 1'b0);
    repeat (8) @(negedge CORE_CLK_I);
    chk({BACKUP_ALARM_O, CHECKSUM_ALARM_O, MONITOR_ALARM_O}, 3'b111);
    SERVO_ON_I = 1'b1;
    ENCODER_SETUP_FUNCTION_I = 1'b1;
    @(negedge CORE_CLK_I);
    chk({SETUP_REFUSE_O, SETUP_ACCEPT_O, BACKUP_ALARM_O}, 3'b101);
    SERVO_ON_I = 1'b0;
    @(negedge CORE_CLK_I);
    chk({SETUP_REFUSE_O, SETUP_ACCEPT_O}, 2'b01);
    ENCODER_SETUP_FUNCTION_I = 1'b0;
    @(negedge CORE_CLK_I);
    chk({BACKUP_ALARM_O, CHECKSUM_ALARM_O, MONITOR_ALARM_O}, 3'b001);
    power(1'b1, 16'hffff);
    chk({INCREMENTAL_MODE_O, SIGNED_MODE_O, MONITOR_ALARM_O}, 3'b110);
    pulse(ENCODER_LIMIT_REWRITE_FUNCTION_I, 1'b0);
    chk(ENC_STORED_LIMIT_I, lim[15:0]);
    power(1'b0, lim[15:0]);
    chk({LIMIT_DISAGREEMENT_ALARM_O, SIGNED_MODE_O}, 2'b00);
    tally_and_finish;
  end
endmodule // absolute_multiturn_tracker_tb
bind amt_tracker amt_tracker_asserts amt_tracker_asserts_i (.*);
`default_nettype wire
